// [hw/bsrb_top.v]
// boundary-scan test logic: TAP, reset/bypass/id registers, pin cells
// assumes test pins arrive asynchronously and are sampled on i_clk;
// the test clock must be far slower than i_clk (bench: 800 ns period)
`include "bsrb_map.vh"
`default_nettype none
module bsrb_top #(
    parameter [31:0] IDCODE_VAL = 32'h0000_0001 // arbitrary value
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_tck,
    input  wire        i_tms,
    input  wire        i_tdi,
    output reg         o_tdo,
    output reg         o_tdo_oe,
    input  wire        i_test_port_enable_fuse,
    input  wire        i_clock_output_fuse,
    output reg         o_clkout_en,
    input  wire        i_reset_pin_n,
    input  wire [3:0]  i_reset_sources,
    output wire        o_device_reset,
    output wire        o_test_port_en,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    input  wire [11:0] i_output_latch_bit,
    input  wire [11:0] i_direction_bit,
    input  wire [11:0] i_alt_en,
    input  wire [11:0] i_alt_out,
    input  wire [11:0] i_alt_oe,
    input  wire [11:0] i_pin,
    output reg  [11:0] o_pin_out,
    output reg  [11:0] o_pin_oe,
    output reg  [11:0] o_pullup_enable_signal,
    output wire [11:0] o_pin_input_value,
    input  wire        i_analog_en,
    input  wire        i_analog_obs,
    output reg         o_analog_en
);

    // one-hot TAP states
    localparam [15:0] ST_TLR   = 16'h0001;
    localparam [15:0] ST_RTI   = 16'h0002;
    localparam [15:0] ST_SELDR = 16'h0004;
    localparam [15:0] ST_CAPDR = 16'h0008;
    localparam [15:0] ST_SHDR  = 16'h0010;
    localparam [15:0] ST_EX1DR = 16'h0020;
    localparam [15:0] ST_PSDR  = 16'h0040;
    localparam [15:0] ST_EX2DR = 16'h0080;
    localparam [15:0] ST_UPDR  = 16'h0100;
    localparam [15:0] ST_SELIR = 16'h0200;
    localparam [15:0] ST_CAPIR = 16'h0400;
    localparam [15:0] ST_SHIR  = 16'h0800;
    localparam [15:0] ST_EX1IR = 16'h1000;
    localparam [15:0] ST_PSIR  = 16'h2000;
    localparam [15:0] ST_EX2IR = 16'h4000;
    localparam [15:0] ST_UPIR  = 16'h8000;

    // chain cell k -> pin index; port A cells run in reverse order
    function [3:0] bsrb_cell_pin;
        input [2:0] k;
        begin
            if (k < 3'h4)
                bsrb_cell_pin = {1'b0, k};
            else
                bsrb_cell_pin = 4'hF - {1'b0, k};
        end
    endfunction

    // TAP state successor
    function [15:0] bsrb_tap_next;
        input [15:0] st;
        input        tms;
        begin
            case (st)
                ST_TLR:   bsrb_tap_next = tms ? ST_TLR   : ST_RTI;
                ST_RTI:   bsrb_tap_next = tms ? ST_SELDR : ST_RTI;
                ST_SELDR: bsrb_tap_next = tms ? ST_SELIR : ST_CAPDR;
                ST_CAPDR: bsrb_tap_next = tms ? ST_EX1DR : ST_SHDR;
                ST_SHDR:  bsrb_tap_next = tms ? ST_EX1DR : ST_SHDR;
                ST_EX1DR: bsrb_tap_next = tms ? ST_UPDR  : ST_PSDR;
                ST_PSDR:  bsrb_tap_next = tms ? ST_EX2DR : ST_PSDR;
                ST_EX2DR: bsrb_tap_next = tms ? ST_UPDR  : ST_SHDR;
                ST_UPDR:  bsrb_tap_next = tms ? ST_SELDR : ST_RTI;
                ST_SELIR: bsrb_tap_next = tms ? ST_TLR   : ST_CAPIR;
                ST_CAPIR: bsrb_tap_next = tms ? ST_EX1IR : ST_SHIR;
                ST_SHIR:  bsrb_tap_next = tms ? ST_EX1IR : ST_SHIR;
                ST_EX1IR: bsrb_tap_next = tms ? ST_UPIR  : ST_PSIR;
                ST_PSIR:  bsrb_tap_next = tms ? ST_EX2IR : ST_PSIR;
                ST_EX2IR: bsrb_tap_next = tms ? ST_UPIR  : ST_SHIR;
                ST_UPIR:  bsrb_tap_next = tms ? ST_SELDR : ST_RTI;
                default:  bsrb_tap_next = ST_TLR;
            endcase
        end
    endfunction

    reg  [15:0] sync1_reg;
    reg  [15:0] sync2_reg;
    reg         tck_d_reg;
    reg  [15:0] state_reg;
    reg  [3:0]  ir_sr_reg;
    reg  [3:0]  ir_reg;
    reg         bypass_reg;
    reg         reset_dr_reg;
    reg  [31:0] id_sr_reg;
    reg  [17:0] bsr_sr_reg;
    reg  [17:0] bsr_upd_reg;
    reg         tpd_reg;
    reg         tpd_pend_reg;
    reg  [2:0]  tpd_cnt_reg;
    reg  [7:0]  ctl_reg;
    reg         srf_reg;
    reg  [3:0]  rcause_reg;
    reg  [17:0] cap_vec;
    reg  [11:0] drv_mask;
    reg  [11:0] drv_out;
    reg  [11:0] drv_oe;
    reg  [11:0] pin_out_next;
    reg  [11:0] pin_oe_next;
    reg  [11:0] pullup_next;
    reg         sel_lsb;
    reg  [3:0]  pidx;
    reg  [3:0]  pidx_u;
    // one index per loop, so no process wakes another through it
    integer     k;
    integer     j;
    integer     m;

    wire        tck_s    = sync2_reg[0];
    wire        tms_s    = sync2_reg[1];
    wire        tdi_s    = sync2_reg[2];
    wire        rstpin_s = sync2_reg[3];
    wire [11:0] pin_s    = sync2_reg[15:4];
    wire        tck_rise = tck_s & ~tck_d_reg;
    wire        tck_fall = ~tck_s & tck_d_reg;
    wire        is_ext   = (ir_reg == `BSRB_IR_EXTEST);
    wire        is_smp   = (ir_reg == `BSRB_IR_SAMPLE);
    wire        scan_md  = is_ext | is_smp;
    wire        clk_pin  = i_clock_output_fuse;
    wire        wr_ctl   = i_wr & (i_addr == `BSRB_ADDR_CPUCTL);
    wire        wr_rc    = i_wr & (i_addr == `BSRB_ADDR_RCAUSE);

    assign o_device_reset    = reset_dr_reg;
    assign o_test_port_en    = i_test_port_enable_fuse & ~tpd_reg;
    // two-flop sampled pin value; the raw i_pin is never passed out directly
    assign o_pin_input_value = pin_s;

    // two-flop sampling of every asynchronous input; only stage 2 is read
    // tck history clears low, its idle level, so no false edge follows
    always @(posedge i_clk) begin
        if (i_rst) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            tck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {i_pin, i_reset_pin_n, i_tdi, i_tms, i_tck};
            sync2_reg <= sync1_reg;
            tck_d_reg <= sync2_reg[0];
        end
    end

    // capture vector: real pin level and system control, per cell
    always @* begin
        cap_vec = 18'h00000;
        pidx    = 4'h0;
        for (k = 0; k < `BSRB_NCELL; k = k + 1) begin
            pidx = bsrb_cell_pin(k[2:0]);
            // second stage: control, the effective direction
            cap_vec[2*k] = i_alt_en[pidx] ? i_alt_oe[pidx]
                                          : i_direction_bit[pidx];
            // first stage: actual pin, clock pin masked
            cap_vec[2*k+1] = pin_s[pidx] &
                             ~((pidx == `BSRB_CLK_PIN) & clk_pin);
        end
        cap_vec[`BSRB_RSTOBS_BIT] = rstpin_s;
        cap_vec[`BSRB_ANALOG_BIT] = i_analog_obs;
    end

    // lsb of the selected path feeds test data out
    always @* begin
        if (state_reg == ST_SHIR)
            sel_lsb = ir_sr_reg[0];
        else begin
            case (ir_reg)
                `BSRB_IR_EXTEST: sel_lsb = bsr_sr_reg[0];
                `BSRB_IR_SAMPLE: sel_lsb = bsr_sr_reg[0];
                `BSRB_IR_IDCODE: sel_lsb = id_sr_reg[0];
                `BSRB_IR_DEVRST: sel_lsb = reset_dr_reg;
                `BSRB_IR_BYPASS: sel_lsb = bypass_reg;
                default:         sel_lsb = bypass_reg;
            endcase
        end
    end

    // TAP engine: state and shifts on tck rise, updates on tck fall
    always @(posedge i_clk) begin
        if (i_rst || !o_test_port_en) begin
            state_reg    <= ST_TLR;
            ir_sr_reg    <= `BSRB_IR_CAPTURE;
            ir_reg       <= `BSRB_IR_IDCODE;
            bypass_reg   <= 1'b0;
            id_sr_reg    <= 32'h0000_0000;
            bsr_sr_reg   <= 18'h00000;
            o_tdo        <= 1'b0;
            o_tdo_oe     <= 1'b0;
            if (i_rst) begin
                reset_dr_reg <= 1'b0;
                bsr_upd_reg  <= 18'h00000;
            end
        end else if (tck_rise) begin
            // a new instruction never touches state_reg
            state_reg <= bsrb_tap_next(state_reg, tms_s);
            if (state_reg == ST_CAPIR)
                ir_sr_reg <= `BSRB_IR_CAPTURE;
            if (state_reg == ST_SHIR)
                ir_sr_reg <= {tdi_s, ir_sr_reg[3:1]};
            if (state_reg == ST_CAPDR) begin
                case (ir_reg)
                    `BSRB_IR_EXTEST: bsr_sr_reg <= cap_vec;
                    `BSRB_IR_SAMPLE: bsr_sr_reg <= cap_vec;
                    `BSRB_IR_IDCODE: id_sr_reg  <= IDCODE_VAL;
                    `BSRB_IR_DEVRST: ;        // no capture here
                    default:         bypass_reg <= 1'b0;
                endcase
            end
            if (state_reg == ST_SHDR) begin
                case (ir_reg)
                    `BSRB_IR_EXTEST, `BSRB_IR_SAMPLE:
                        bsr_sr_reg <= {tdi_s, bsr_sr_reg[17:1]};
                    `BSRB_IR_IDCODE:
                        id_sr_reg <= {tdi_s, id_sr_reg[31:1]};
                    `BSRB_IR_DEVRST:
                        reset_dr_reg <= tdi_s;
                    default:
                        bypass_reg <= tdi_s;
                endcase
            end
        end else if (tck_fall) begin
            o_tdo    <= sel_lsb;
            o_tdo_oe <= (state_reg == ST_SHDR) | (state_reg == ST_SHIR);
            if (state_reg == ST_UPIR)
                ir_reg <= ir_sr_reg;
            if (state_reg == ST_TLR)
                ir_reg <= `BSRB_IR_IDCODE;
            // shift stage only reaches pins here
            if ((state_reg == ST_UPDR) && scan_md)
                bsr_upd_reg <= bsr_sr_reg;
        end
    end

    // update stage per scanned pin, from latched cells
    always @* begin
        drv_mask = 12'h000;
        drv_out  = 12'h000;
        drv_oe   = 12'h000;
        pidx_u   = 4'h0;
        for (j = 0; j < `BSRB_NCELL; j = j + 1) begin
            pidx_u = bsrb_cell_pin(j[2:0]);
            drv_mask[pidx_u] = 1'b1;
            drv_out[pidx_u]  = bsr_upd_reg[2*j+1];
            drv_oe[pidx_u]   = bsr_upd_reg[2*j];
        end
    end

    // pad drive: system path with alternates first, scan on top
    always @* begin
        pin_out_next = 12'h000;
        pin_oe_next  = 12'h000;
        pullup_next  = 12'h000;
        for (m = 0; m < `BSRB_NPIN; m = m + 1) begin
            // alternate function ahead of the cell
            pin_out_next[m] = i_alt_en[m] ? i_alt_out[m]
                                          : i_output_latch_bit[m];
            pin_oe_next[m]  = (i_alt_en[m] ? i_alt_oe[m]
                                           : i_direction_bit[m]) &
                              ~reset_dr_reg;
            // EXTEST drives latched cells from load onward
            if (is_ext && drv_mask[m]) begin
                pin_out_next[m] = drv_out[m];
                pin_oe_next[m]  = drv_oe[m];
            end
            // port F 4..7 carry the test port while it is on
            if (o_test_port_en && (m >= `BSRB_TAP_LO) &&
                (m <= `BSRB_TAP_HI))
                pin_oe_next[m] = 1'b0;
            pullup_next[m] = ~ctl_reg[`BSRB_BIT_PULLOFF] &
                             ~i_direction_bit[m] &
                             i_output_latch_bit[m] & ~scan_md;
        end
    end

    // registered pad and analog controls
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pin_out              <= 12'h000;
            o_pin_oe               <= 12'h000;
            o_pullup_enable_signal <= 12'h000;
            o_clkout_en            <= 1'b0;
            o_analog_en            <= 1'b0;
        end else begin
            o_pin_out              <= pin_out_next;
            o_pin_oe               <= pin_oe_next;
            o_pullup_enable_signal <= pullup_next;
            o_clkout_en            <= clk_pin & ~scan_md;
            // contention guard: analog drivers off in scan
            o_analog_en            <= i_analog_en & ~scan_md;
        end
    end

    // control register with the timed disable bit
    // any write that does not complete a pair re-arms the window
    always @(posedge i_clk) begin
        if (i_rst) begin
            ctl_reg      <= `BSRB_CTL_RESET;
            tpd_reg      <= 1'b0;
            tpd_pend_reg <= 1'b0;
            tpd_cnt_reg  <= 3'h0;
        end else begin
            if (tpd_cnt_reg != 3'h0)
                tpd_cnt_reg <= tpd_cnt_reg - 3'h1;
            if (wr_ctl) begin
                ctl_reg <= i_wdata & `BSRB_CTL_PLAIN;
                // second equal write inside the window commits
                if ((tpd_cnt_reg != 3'h0) &&
                    (tpd_pend_reg == i_wdata[`BSRB_BIT_TPD])) begin
                    tpd_reg     <= tpd_pend_reg;
                    tpd_cnt_reg <= 3'h0;
                end else begin
                    // single writes only arm the window
                    tpd_pend_reg <= i_wdata[`BSRB_BIT_TPD];
                    tpd_cnt_reg  <= `BSRB_TIMED_WIN;
                end
            end
        end
    end

    // reset cause flags: setting beats a same-cycle zero write
    // a zero write cannot hide a scan reset that is still held
    always @(posedge i_clk) begin
        if (i_rst) begin
            srf_reg    <= 1'b0; // power-on clears the flag
            rcause_reg <= 4'h0;
        end else begin
            if (reset_dr_reg)
                srf_reg <= 1'b1;
            else if (wr_rc && !i_wdata[`BSRB_BIT_SRF])
                srf_reg <= 1'b0;
            if (wr_rc)
                rcause_reg <= (rcause_reg & i_wdata[3:0]) |
                              i_reset_sources;
            else
                rcause_reg <= rcause_reg | i_reset_sources;
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always @(posedge i_clk) begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd && (i_addr == `BSRB_ADDR_RCAUSE))
            o_rdata <= {3'h0, srf_reg, rcause_reg};
        else if (i_rd && (i_addr == `BSRB_ADDR_CPUCTL))
            o_rdata <= {tpd_reg, ctl_reg[6:0]};
        else
            o_rdata <= 8'h00;
    end

endmodule // bsrb_top
`default_nettype wire

// [include/bsrb_map.vh]
// constants for the boundary-scan reset/bypass block
// assumes a 10 MHz core clock and a slower external test clock
//
// Overview of operation
// - code C picks the one-bit reset register; TAP state is untouched
// - device reset follows the reset register bit directly, no latch
// - under device reset only Shift-DR acts, shifting the one bit
// - code F puts the single bypass cell between data in and out
// - bypass loads zero at Capture-DR and shifts one cell at Shift-DR
// - pull-ups are off while EXTEST or SAMPLE_PRELOAD is loaded
// - each pin cell packs control, data and input into two stages
// - plain pin: input raw, data from latch, control from direction
// - alternate functions join outside the cell; chain sees real pin
// - no analog stage; digital controls to analog forced off in scan
// - system clock not sent to pins under EXTEST or SAMPLE_PRELOAD
// - a clock present on a pin is never captured into the chain
// - reset pin has an observe-only cell catching the low reset
// - control bit 7 zero with fuse enables test port; one disables
// - disable bit changes only on two equal writes within four cycles
// - reset-cause bit 4 sets on scan reset; clears on power-on or 0
// - chain bit 0 is least significant, first in and first out
// - chain follows pin-out, port A reversed, reset-pin and analog bits on top
// - data maps to the first cell stage, control to the second
// - port F bits 4 to 7 are test port pins and not in the chain
// - instruction register is four bits; all shifts go LSB first
// - EXTEST code 0 drives latched cells at once; Update-DR applies
// - SAMPLE_PRELOAD code 2 snapshots pins, loads latches, no drive
`ifndef BSRB_MAP_VH
`define BSRB_MAP_VH
`define BSRB_ADDR_RCAUSE  8'h34
`define BSRB_ADDR_CPUCTL  8'h35
`define BSRB_BIT_TPD      7
`define BSRB_BIT_PULLOFF  4
`define BSRB_BIT_SRF      4
`define BSRB_CTL_PLAIN    8'h13
`define BSRB_CTL_RESET    8'h00
`define BSRB_TIMED_WIN    3'h4
`define BSRB_IR_EXTEST    4'h0
`define BSRB_IR_IDCODE    4'h1
`define BSRB_IR_SAMPLE    4'h2
`define BSRB_IR_DEVRST    4'hC
`define BSRB_IR_BYPASS    4'hF
`define BSRB_IR_CAPTURE   4'h1
`define BSRB_NPIN         12
`define BSRB_NCELL        8
`define BSRB_CHAIN_W      18
`define BSRB_RSTOBS_BIT   16
`define BSRB_ANALOG_BIT   17
`define BSRB_CLK_PIN      3
`define BSRB_TAP_LO       4
`define BSRB_TAP_HI       7
`define BSRB_NSYNC        16
`endif

// [tb/bsrb_tap_model.sv]
// model of the external boundary-scan controller on the test port
// assumes the block finds tck edges on its own clock; tck period 800 ns
`default_nettype none
module bsrb_tap_model (
    input  wire logic i_tdo,
    output var  logic o_tck,
    output var  logic o_tms,
    output var  logic o_tdi
);
    timeunit 1ns;
    timeprecision 1ns;
    // tck parks low between frames; tdi flips so stale data never passes
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // one tck period: drive in the low phase, sample tdo on the rise
    task step(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #400 o_tck = 1'b1;
        tdo = i_tdo;
        #400 o_tck = 1'b0;
    endtask
    // five high tms bits reach reset from any state, then park in idle
    task reset_tap();
        logic t;
        #13;
        repeat (5) step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask
    // from idle: walk to shift, move n bits, update, back to idle
    task scan(input logic ir, input int n, input logic [31:0] din,
              output logic [31:0] dout);
        logic t;
        dout = '0;
        #13;
        step(1'b1, 1'b0, t);
        if (ir)
            step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        // lsb leaves first, last bit moves on to exit
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], t);
            dout[i] = t;
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        o_tdi = ~o_tdi;
    endtask
endmodule // bsrb_tap_model
`default_nettype wire

// [tb/bsrb_top_props.sv]
// port-level checker for the boundary-scan block, bound to bsrb_top
// assumes a single core clock domain with synchronous reset i_rst
`default_nettype none
module bsrb_top_props (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_test_port_enable_fuse,
    input wire logic        i_clock_output_fuse,
    input wire logic        i_analog_en,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  i_addr,
    input wire logic [11:0] i_output_latch_bit,
    input wire logic [11:0] i_direction_bit,
    input wire logic        o_tdo_oe,
    input wire logic        o_clkout_en,
    input wire logic        o_device_reset,
    input wire logic        o_test_port_en,
    input wire logic [7:0]  o_rdata,
    input wire logic [11:0] o_pin_oe,
    input wire logic [11:0] o_pullup_enable_signal,
    input wire logic        o_analog_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_port_fuse: assert property (
        o_test_port_en |-> i_test_port_enable_fuse)
        else $error("test port enabled without fuse");
    // a disabled port holds the tap in reset, so tdo never drives
    a_port_quiet: assert property (
        !o_test_port_en [*8] |-> !o_tdo_oe)
        else $error("tdo driven while port disabled");
    a_timed_pair: assert property (
        $changed(o_test_port_en) && $stable(i_test_port_enable_fuse)
        |-> $past(i_wr) && $past(i_addr) == 8'h35 && ($past(i_wr, 2)
        || $past(i_wr, 3) || $past(i_wr, 4) || $past(i_wr, 5)))
        else $error("disable bit moved without a timed pair");
    a_pullup_terms: assert property (
        (o_pullup_enable_signal & ~($past(i_output_latch_bit)
        & ~$past(i_direction_bit))) == 12'h000)
        else $error("pull-up on for an output or low latch");
    a_clkout_fuse: assert property (
        o_clkout_en |-> $past(i_clock_output_fuse))
        else $error("clock out without fuse");
    a_analog_gate: assert property (
        o_analog_en |-> $past(i_analog_en))
        else $error("analog control on without request");
    a_reset_shift: assert property (
        $changed(o_device_reset) |-> o_tdo_oe)
        else $error("device reset moved outside shift");
    a_read_idle: assert property (
        !($past(i_rd) && ($past(i_addr) == 8'h34
        || $past(i_addr) == 8'h35)) |-> o_rdata == 8'h00)
        else $error("read data outside a mapped read");
    a_ctl_spare: assert property (
        $past(i_rd) && $past(i_addr) == 8'h35 |-> (o_rdata & 8'h6C) == 0)
        else $error("control spare bits not zero");
    a_cause_spare: assert property (
        $past(i_rd) && $past(i_addr) == 8'h34 |-> o_rdata[7:5] == 3'h0)
        else $error("reset cause spare bits not zero");
    a_tap_pins: assert property (
        o_test_port_en && $past(o_test_port_en) |-> o_pin_oe[7:4] == 4'h0)
        else $error("test port pin driven by port logic");
endmodule // bsrb_top_props
bind bsrb_top bsrb_top_props props_u (.*);
`default_nettype wire

// [tb/bsrb_top_tb_top.sv]
// self-checking bench for bsrb_top with a modelled scan controller
// assumes a 10 MHz core clock; pads resolved from drive enables here
`include "bsrb_map.vh"
`default_nettype none
module bsrb_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, tck, tms, tdi, tdo, tdo_oe, fuse_en, fuse_ck;
    logic        clock_output_fuse, rstn, dev_rst, tpe, wr, rd, an_en, an_obs, an_o;
    logic [3:0]  srcs;
    logic [7:0]  addr, wdata, rdata;
    logic [11:0] latch, dir, alt_en, alt_out, alt_oe, pin, pout, poe;
    logic [11:0] pup, pin_in, ext;
    int          n_fail, checks, cyc;
    localparam logic [31:0] ID_VAL = 32'h1234_5671; // arbitrary value
    // pad level: driven where enabled, outside world elsewhere
    assign pin = (poe & pout) | (~poe & ext);
    bsrb_top #(.IDCODE_VAL(ID_VAL)) dut_u (.i_clk(clk), .i_rst(rst),
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .i_test_port_enable_fuse(fuse_en), .i_clock_output_fuse(fuse_ck),
        .o_clkout_en(clock_output_fuse), .i_reset_pin_n(rstn), .i_reset_sources(srcs),
        .o_device_reset(dev_rst), .o_test_port_en(tpe), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_output_latch_bit(latch), .i_direction_bit(dir),
        .i_alt_en(alt_en), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
        .i_pin(pin), .o_pin_out(pout), .o_pin_oe(poe),
        .o_pullup_enable_signal(pup), .o_pin_input_value(pin_in),
        .i_analog_en(an_en), .i_analog_obs(an_obs), .o_analog_en(an_o));
    bsrb_tap_model tap (.i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard: all scenarios need well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            complete_run();
        end
    end
    task complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // strobe stays high until idle or rd8 drops it; back-to-back calls write on consecutive edges
    task wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask
    task idle(input int n);
        repeat (n) begin
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task t_ctl();
        logic [7:0] r;
        rd8(8'h35, r);
        chk(r, 8'h00, "control after reset");
        rd8(8'h36, r);
        chk(r, 8'h00, "unmapped read");
        wr8(8'h36, 8'hFF);
        wr8(8'h35, 8'hFF);
        idle(6);
        rd8(8'h35, r);
        chk({tpe, r}, 9'h113, "single write");
        // no debug session runs here, so the disable bit may move
        wr8(8'h35, 8'h80);
        idle(4);
        wr8(8'h35, 8'h80);
        idle(6);
        rd8(8'h35, r);
        chk({tpe, r}, 9'h100, "pair too far apart");
        wr8(8'h35, 8'h80);
        idle(3);
        wr8(8'h35, 8'h80);
        idle(10);
        rd8(8'h35, r);
        chk({tpe, r, tdo_oe}, 10'h100, "port disabled");
        wr8(8'h35, 8'h00);
        wr8(8'h35, 8'h00);
        idle(2);
        chk(tpe, 1'b1, "port enabled again");
        fuse_en <= 1'b0;
        idle(1);
        chk(tpe, 1'b0, "fuse off");
        fuse_en <= 1'b1;
        $display("test ctl done");
    endtask
    task t_bypass();
        logic [31:0] d;
        logic [3:0]  c;
        tap.reset_tap();
        tap.scan(1'b0, 32, 32'h0, d);
        chk(d, ID_VAL, "default id path");
        // code F and an unused code both route through the bypass cell
        for (int i = 0; i < 2; i++) begin
            c = i ? 4'h5 : `BSRB_IR_BYPASS;
            tap.scan(1'b1, 4, {28'h0, c}, d);
            chk(d[3:0], 4'h1, "ir capture");
            tap.scan(1'b0, 8, 32'hB5, d);
            chk(d[7:0], 8'h6A, "bypass path");
        end
        $display("test bypass done");
    endtask
    task t_devrst();
        logic [31:0] d;
        logic [7:0]  r;
        tap.scan(1'b1, 4, 32'hC, d);
        tap.scan(1'b0, 1, 32'h1, d);
        chk(dev_rst, 1'b1, "reset held");
        rd8(8'h34, r);
        chk(r, 8'h10, "scan reset flag");
        tap.scan(1'b0, 1, 32'h0, d);
        chk({d[0], dev_rst}, 2'h2, "reset bit kept and released");
        @(posedge clk);
        srcs <= 4'h5;
        @(posedge clk);
        srcs <= 4'h0;
        rd8(8'h34, r);
        chk(r, 8'h15, "other causes");
        wr8(8'h34, 8'hEF);
        rd8(8'h34, r);
        chk(r, 8'h05, "flag cleared by zero");
        wr8(8'h34, 8'h00);
        rd8(8'h34, r);
        chk(r, 8'h00, "all cleared");
        $display("test devrst done");
    endtask
    // cell k sits on pin k for port F, pins 11 down to 8 for port A
    task pins_from(input logic [17:0] p);
        logic [11:0] eo, ed;
        eo = '0;
        ed = '0;
        for (int k = 0; k < 8; k++) begin
            eo[k < 4 ? k : 15 - k] = p[2 * k];
            ed[k < 4 ? k : 15 - k] = p[2 * k + 1];
        end
        chk(poe, eo, "extest enables");
        chk(pout & eo, ed & eo, "extest data");
    endtask
    task t_scan_pins();
        logic [31:0] d;
        logic [17:0] e;
        logic [11:0] pv;
        @(posedge clk);
        ext <= 12'hA5C;
        latch <= 12'hFFF;
        alt_en <= 12'h002;
        alt_oe <= 12'h002;
        alt_out <= 12'h002;
        fuse_ck <= 1'b1;
        an_en <= 1'b1;
        an_obs <= 1'b1;
        idle(8);
        chk(pup & 12'hF0D, 12'hF0D, "pull-ups normal");
        chk({clock_output_fuse, an_o, pin_in}, 14'h3A5E, "normal pins");
        tap.scan(1'b1, 4, 32'h2, d);
        chk({pup, clock_output_fuse}, 13'h0, "sample gating");
        tap.scan(1'b0, 18, 32'h2B4E7, d);
        // clock pin 3 reads zero; alternate drive shows on pin 1
        pv = 12'hA56;
        e = 18'h30000;
        for (int k = 0; k < 8; k++)
            e[2 * k + 1] = pv[k < 4 ? k : 15 - k];
        chk(d[17:0] & 18'h3AAAA, e, "capture");
        chk(poe, 12'h002, "sample leaves pins");
        tap.scan(1'b1, 4, 32'h0, d);
        pins_from(18'h2B4E7);
        chk({pup, clock_output_fuse, an_o}, 14'h0, "extest gating");
        tap.scan(1'b0, 18, 32'h14B18, d);
        pins_from(18'h14B18);
        $display("test scan pins done");
    endtask
    initial begin
        rst = 1'b1;
        {fuse_en, rstn} = 2'b11;
        {fuse_ck, an_en, an_obs, wr, rd} = '0;
        {srcs, addr, wdata} = '0;
        {latch, dir, alt_en, alt_out, alt_oe, ext} = '0;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_ctl();
        t_bypass();
        t_devrst();
        t_scan_pins();
        complete_run();
    end
endmodule // bsrb_top_tb_top
`default_nettype wire
